// file: tacs_params.svh
`ifndef TACS_PARAMS_SVH
`define TACS_PARAMS_SVH
`define TACS_CMD_PREFIX 8'h06
`define TACS_OPEN_SECOND 8'h00
`define TACS_CALL_SECOND 8'h04
`define TACS_PROBE_NIBBLE 4'h6
`define TACS_PICK_CODE 8'h0E
`define TACS_SLOT_COUNT 5'h10
`define TACS_SLOT_LAST 4'hF
`define TACS_LFSR_SEED 16'hACE1
`define TACS_LFSR_TAPS 16'hB400
`define TACS_ANS_WAIT 8'h40
`endif

// file: tacs_pkg.sv
package tacs_pkg;
  typedef enum logic [1:0] {TACS_READY, TACS_INVENTORY, TACS_SELECTED, TACS_DESELECTED} tacs_state_t;
  typedef logic [7:0] tacs_byte_t;
endpackage

// file: tacs_link_if.sv
`timescale 1ns/10ps
// Byte-level link: request frames reader to tag, answer bytes tag to reader
interface tacs_link_if;
  logic req_valid;
  logic [7:0] req_byte;
  logic req_last;
  logic req_crc_ok;
  logic ans_valid;
  logic [7:0] ans_byte;
  modport tag (input req_valid, input req_byte, input req_last, input req_crc_ok,
               output ans_valid, output ans_byte);
  modport reader (output req_valid, output req_byte, output req_last, output req_crc_ok,
                  input ans_valid, input ans_byte);
endinterface

// file: tacs_lfsr.sv
`timescale 1ns/10ps
`include "tacs_params.svh"
// Free-running Galois LFSR random source
module tacs_lfsr (
  input wire logic clk,
  input wire logic rst_n,
  output logic [15:0] rnd
);
  import tacs_pkg::*;
  // Shift every cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rnd <= `TACS_LFSR_SEED;
    end else begin
      rnd <= rnd[0] ? ((rnd >> 1) ^ `TACS_LFSR_TAPS) : (rnd >> 1);
    end
  end
endmodule

// file: tacs_tag.sv
`timescale 1ns/10ps
`include "tacs_params.svh"
module tacs_tag (
  input wire logic clk,
  input wire logic rst_n,
  tacs_link_if.tag link,
  output tacs_pkg::tacs_state_t state,
  output tacs_pkg::tacs_byte_t tag_handle
);
  import tacs_pkg::*;
  logic [15:0] rnd;
  logic [7:0] b0_r;
  logic [7:0] b1_r;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic ans_valid_r;
  logic [7:0] ans_byte_r;
  logic got_open;
  logic got_call;
  logic got_probe;
  logic got_pick;
  logic frame_end;

  tacs_lfsr u_lfsr (
    .clk(clk),
    .rst_n(rst_n),
    .rnd(rnd)
  );

  assign link.ans_valid = ans_valid_r;
  assign link.ans_byte = ans_byte_r;

  // Capture first two data bytes of a frame
  assign cnt_nxt = (cnt_r == 2'h3) ? cnt_r : cnt_r + 2'h1;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= 2'h0;
      b0_r <= 8'h00;
      b1_r <= 8'h00;
    end else if (link.req_valid) begin
      if (cnt_r == 2'h0) b0_r <= link.req_byte;
      if (cnt_r == 2'h1) b1_r <= link.req_byte;
      cnt_r <= link.req_last ? 2'h0 : cnt_nxt;
    end
  end

  // Decode at frame end; last byte may be the second
  assign frame_end = link.req_valid && link.req_last && link.req_crc_ok;
  always_comb begin
    got_open = 1'b0;
    got_call = 1'b0;
    got_probe = 1'b0;
    got_pick = 1'b0;
    if (frame_end) begin
      if (cnt_r == 2'h1 && b0_r == `TACS_CMD_PREFIX) begin
        got_open = (link.req_byte == `TACS_OPEN_SECOND);
        got_call = (link.req_byte == `TACS_CALL_SECOND);
      end
      if (cnt_r == 2'h0 && link.req_byte[3:0] == `TACS_PROBE_NIBBLE &&
          link.req_byte[7:4] != 4'h0) begin
        got_probe = 1'b1;
      end
      if (cnt_r == 2'h1 && b0_r == `TACS_PICK_CODE) begin
        got_pick = 1'b1;
      end
    end
  end

  // State machine
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= TACS_READY;
    end else begin
      unique case (state)
        TACS_READY: if (got_open) state <= TACS_INVENTORY;
        TACS_INVENTORY: if (got_pick && link.req_byte == tag_handle) state <= TACS_SELECTED;
        TACS_SELECTED: if (got_pick && link.req_byte != tag_handle) state <= TACS_DESELECTED;
        TACS_DESELECTED: if (got_pick && link.req_byte == tag_handle) state <= TACS_SELECTED;
      endcase
    end
  end

  // Handle and slot field updates
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tag_handle <= 8'h00;
    end else if (got_open && (state == TACS_READY || state == TACS_INVENTORY)) begin
      tag_handle <= rnd[7:0];
    end else if (got_call && state == TACS_INVENTORY) begin
      tag_handle <= {tag_handle[7:4], rnd[11:8]};
    end
  end

  // Answer byte generation
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ans_valid_r <= 1'b0;
      ans_byte_r <= 8'h00;
    end else begin
      ans_valid_r <= 1'b0;
      if (got_open && (state == TACS_READY || state == TACS_INVENTORY)) begin
        ans_valid_r <= 1'b1;
        ans_byte_r <= rnd[7:0];
      end else if (got_call && state == TACS_INVENTORY && rnd[11:8] == 4'h0) begin
        ans_valid_r <= 1'b1;
        ans_byte_r <= {tag_handle[7:4], 4'h0};
      end else if (got_probe && state == TACS_INVENTORY &&
                   link.req_byte[7:4] == tag_handle[3:0]) begin
        ans_valid_r <= 1'b1;
        ans_byte_r <= tag_handle;
      end else if (got_pick && link.req_byte == tag_handle &&
                   state != TACS_READY) begin
        ans_valid_r <= 1'b1;
        ans_byte_r <= tag_handle;
      end
    end
  end
endmodule

// file: tacs_reader.sv
`timescale 1ns/10ps
`include "tacs_params.svh"
// Reader end: runs open, slot rounds, and picks single answers
module tacs_reader (
  input wire logic clk,
  input wire logic rst_n,
  tacs_link_if.reader link,
  input wire logic start,
  input wire logic ans_collide,
  output logic found_valid,
  output logic [7:0] found_handle,
  output logic busy
);
  import tacs_pkg::*;
  typedef enum {RD_IDLE, RD_SEND, RD_WAIT, RD_PICK, RD_PWAIT} tacs_rd_t;
  tacs_rd_t st_r;
  logic [3:0] slot_r;
  logic round_r;
  logic coll_r;
  logic [7:0] wait_r;
  logic [7:0] got_r;
  logic got_v_r;
  logic [1:0] idx_r;
  logic [1:0] len;
  logic [7:0] cur;

  // Command bytes per step
  always_comb begin
    len = 2'h1;
    cur = {slot_r, `TACS_PROBE_NIBBLE};
    if (st_r == RD_PICK) begin
      cur = (idx_r == 2'h0) ? `TACS_PICK_CODE : got_r;
    end else if (!round_r || slot_r == 4'h0) begin
      cur = (idx_r == 2'h0) ? `TACS_CMD_PREFIX :
            (round_r ? `TACS_CALL_SECOND : `TACS_OPEN_SECOND);
    end
    if (st_r == RD_PICK || !round_r || slot_r == 4'h0) len = 2'h2;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= RD_IDLE;
      slot_r <= 4'h0;
      round_r <= 1'b0;
      coll_r <= 1'b0;
      wait_r <= 8'h00;
      got_r <= 8'h00;
      got_v_r <= 1'b0;
      idx_r <= 2'h0;
      link.req_valid <= 1'b0;
      link.req_byte <= 8'h00;
      link.req_last <= 1'b0;
      link.req_crc_ok <= 1'b0;
      found_valid <= 1'b0;
      found_handle <= 8'h00;
      busy <= 1'b0;
    end else begin
      link.req_valid <= 1'b0;
      link.req_last <= 1'b0;
      found_valid <= 1'b0;
      unique case (st_r)
        RD_IDLE: if (start) begin
          st_r <= RD_SEND;
          round_r <= 1'b0;
          slot_r <= 4'h0;
          idx_r <= 2'h0;
          busy <= 1'b1;
        end
        RD_SEND, RD_PICK: begin
          link.req_valid <= 1'b1;
          link.req_byte <= cur;
          link.req_crc_ok <= 1'b1;
          link.req_last <= (idx_r == len - 2'h1);
          idx_r <= idx_r + 2'h1;
          if (idx_r == len - 2'h1) begin
            idx_r <= 2'h0;
            wait_r <= `TACS_ANS_WAIT;
            got_v_r <= 1'b0;
            st_r <= (st_r == RD_PICK) ? RD_PWAIT : RD_WAIT;
          end
        end
        RD_WAIT: begin
          if (link.ans_valid) begin
            got_r <= link.ans_byte;
            got_v_r <= 1'b1;
          end
          wait_r <= wait_r - 8'h01;
          if (wait_r == 8'h00) begin
            if (ans_collide) begin
              coll_r <= 1'b1;
              if (!round_r) begin
                round_r <= 1'b1;
                slot_r <= 4'h0;
                coll_r <= 1'b0;
                st_r <= RD_SEND;
              end else begin
                st_r <= RD_SEND;
              end
            end else if (got_v_r) begin
              st_r <= RD_PICK;
            end else begin
              st_r <= RD_SEND;
            end
            if (round_r && !(ans_collide == 1'b0 && got_v_r)) begin
              if (slot_r == `TACS_SLOT_LAST) begin
                slot_r <= 4'h0;
                round_r <= coll_r || ans_collide;
                coll_r <= 1'b0;
                if (!(coll_r || ans_collide)) begin
                  st_r <= RD_IDLE;
                  busy <= 1'b0;
                end
              end else begin
                slot_r <= slot_r + 4'h1;
              end
            end
          end
        end
        RD_PWAIT: begin
          wait_r <= wait_r - 8'h01;
          if (wait_r == 8'h00) begin
            found_valid <= 1'b1;
            found_handle <= got_r;
            st_r <= RD_SEND;
            if (round_r) begin
              if (slot_r == `TACS_SLOT_LAST) begin
                slot_r <= 4'h0;
                round_r <= coll_r;
                coll_r <= 1'b0;
                if (!coll_r) begin
                  st_r <= RD_IDLE;
                  busy <= 1'b0;
                end
              end else begin
                slot_r <= slot_r + 4'h1;
              end
            end
          end
        end
      endcase
    end
  end
endmodule

// file: tacs_chk.sv
`timescale 1ns/10ps
module tacs_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic [7:0] req_byte,
  input wire logic req_last,
  input wire logic req_crc_ok,
  input wire logic ans_valid,
  input wire logic [7:0] ans_byte
);
  logic infr_r;
  logic [7:0] prev_r;
  logic lst;
  // Frame position and previous byte
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      infr_r <= 1'b0;
      prev_r <= 8'h00;
    end else if (req_valid) begin
      infr_r <= !req_last;
      prev_r <= req_byte;
    end
  end
  // Good frame completes this cycle
  assign lst = req_valid && req_last && req_crc_ok;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ans_cause_a: assert property (ans_valid |-> $past(lst))
    else $error("answer without a good frame");
  ans_pulse_a: assert property (ans_valid |=> !ans_valid)
    else $error("answer held too long");
  call_zero_a: assert property (lst && infr_r && prev_r == 8'h06 && req_byte == 8'h04
    |=> !ans_valid || ans_byte[3:0] == 4'h0) else $error("call answer slot not zero");
  probe_match_a: assert property (lst && !infr_r && req_byte[3:0] == 4'h6
    |=> !ans_valid || ans_byte[3:0] == $past(req_byte[7:4])) else $error("probe slot mismatch");
  probe_nonzero_a: assert property (lst && !infr_r && req_byte[3:0] == 4'h6
    |-> req_byte[7:4] != 4'h0) else $error("probe of slot zero");
  pick_echo_a: assert property (lst && infr_r && prev_r == 8'h0E
    |=> !ans_valid || ans_byte == $past(req_byte)) else $error("pick answer not handle");
  bad_crc_a: assert property (req_valid && req_last && !req_crc_ok |=> !ans_valid)
    else $error("answer to bad frame");
  two_byte_a: assert property (req_valid && req_last && infr_r
    |-> prev_r == 8'h06 || prev_r == 8'h0E) else $error("bad command prefix");
  cover property (lst && !infr_r);
  cover property (ans_valid && ans_byte[3:0] == 4'h0);
  cover property (lst && infr_r && prev_r == 8'h0E);
endmodule

// file: tag_anticollision_slots_tb.sv
`timescale 1ns/10ps
module tag_anticollision_slots_tb;
  import tacs_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  logic start = 0;
  logic ans_collide = 0;
  logic found_valid, busy, got;
  logic [7:0] found_handle, ans, slot;
  tacs_state_t st_a, st_b;
  tacs_byte_t hd_a, hd_b;
  int n_fail = 0;
  int n_tests = 0;
  int n;
  tacs_link_if link_a ();
  tacs_link_if link_b ();
  tacs_tag i_tacs_tag (.clk(clk), .rst_n(rst_n), .link(link_a), .state(st_a), .tag_handle(hd_a));
  tacs_reader i_tacs_reader (.clk(clk), .rst_n(rst_n), .link(link_a), .start(start),
    .ans_collide(ans_collide), .found_valid(found_valid), .found_handle(found_handle),
    .busy(busy));
  tacs_tag i_tacs_tag_b (.clk(clk), .rst_n(rst_n), .link(link_b), .state(st_b), .tag_handle(hd_b));
  tacs_chk i_tacs_chk (.clk(clk), .rst_n(rst_n), .req_valid(link_a.req_valid),
    .req_byte(link_a.req_byte), .req_last(link_a.req_last), .req_crc_ok(link_a.req_crc_ok),
    .ans_valid(link_a.ans_valid), .ans_byte(link_a.ans_byte));
  // Clock
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic chk_b(logic [7:0] g, logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %0t byte %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_s(tacs_state_t g, tacs_state_t e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %0t state %0d exp %0d", $time, g, e);
    end
  endtask
  task automatic wrap_up();
    if (n_fail == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // One request frame to the second tag, answer caught one cycle on
  task automatic xfer(logic [7:0] b0, logic [7:0] b1, int nb, logic crc);
    @(negedge clk);
    link_b.req_valid = 1'b1;
    link_b.req_byte = b0;
    link_b.req_last = (nb == 1);
    link_b.req_crc_ok = crc;
    if (nb == 2) begin
      @(negedge clk);
      link_b.req_byte = b1;
      link_b.req_last = 1'b1;
    end
    @(negedge clk);
    link_b.req_valid = 1'b0;
    link_b.req_last = 1'b0;
    link_b.req_byte = ~link_b.req_byte;
    got = link_b.ans_valid;
    ans = link_b.ans_byte;
    @(negedge clk);
  endtask
  initial begin
    link_b.req_valid = 1'b0;
    link_b.req_byte = 8'h00;
    link_b.req_last = 1'b0;
    link_b.req_crc_ok = 1'b0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    // Ready tag ignores slot commands and bad frames
    xfer(8'h06, 8'h04, 2, 1);
    chk_b({7'h00, got}, 8'h00);
    xfer(8'h16, 8'h00, 1, 1);
    chk_b({7'h00, got}, 8'h00);
    xfer(8'h06, 8'h00, 2, 0);
    chk_s(st_b, TACS_READY);
    xfer(8'h06, 8'h05, 2, 1);
    chk_s(st_b, TACS_READY);
    xfer(8'h06, 8'h00, 2, 1);
    chk_b({7'h00, got}, 8'h01);
    chk_b(ans, hd_b);
    chk_s(st_b, TACS_INVENTORY);
    xfer(8'h06, 8'h00, 1, 1);
    chk_b({7'h00, got}, 8'h00);
    // Slot rounds: call then probes 1..15
    for (int r = 0; r < 40; r++) begin
      xfer(8'h06, 8'h04, 2, 1);
      slot = hd_b;
      chk_b({7'h00, got}, {7'h00, slot[3:0] == 4'h0});
      if (got)
        chk_b(ans, slot);
      for (int s = 1; s < 16; s++) begin
        xfer({s[3:0], 4'h6}, 8'h00, 1, 1);
        chk_b({7'h00, got}, {7'h00, slot[3:0] == s[3:0]});
        if (got)
          chk_b(ans, slot);
      end
      chk_b(hd_b, slot);
    end
    // Pick by handle, then silent to anticollision
    xfer(8'h0E, ~slot, 2, 1);
    chk_s(st_b, TACS_INVENTORY);
    xfer(8'h0E, slot, 2, 1);
    chk_b(ans, slot);
    chk_s(st_b, TACS_SELECTED);
    xfer(8'h06, 8'h04, 2, 1);
    chk_b({7'h00, got}, 8'h00);
    xfer({slot[3:0], 4'h6}, 8'h00, 1, 1);
    chk_b({7'h00, got}, 8'h00);
    // Reader against tag: collision on open forces a slot round
    @(negedge clk);
    start = 1'b1;
    ans_collide = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (100) @(negedge clk);
    ans_collide = 1'b0;
    n = 0;
    while (found_valid !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    if (n == 5000) begin
      n_fail++;
    end else begin
      chk_b(found_handle, hd_a);
      chk_b({7'h00, busy}, 8'h01);
      @(negedge clk);
      chk_s(st_a, TACS_SELECTED);
      // Round ends clean after the single tag is found
      n = 0;
      while (busy !== 1'b0 && n < 2000) begin
        @(negedge clk);
        n++;
      end
      if (n == 2000)
        n_fail++;
      chk_b({7'h00, busy}, 8'h00);
    end
    wrap_up();
  end
endmodule
